// file: design/rsw_top.sv
// rsw_top: reset-cause recording, wakeup identification, boot choice, retention
// and debug/clock status for the recovery path from stop modes.
// assumes: rst is the system (warm) reset; por_rst the chip power-on reset; cause inputs
// are asynchronous pulses/levels from reset sources, synchronised here.
module rsw_top
  import rsw_pkg::*;
#(
  parameter int unsigned N_GATES = rsw_pkg::NUM_GATES
) (
  input  wire logic                    clk,
  input  wire logic                    rst,
  input  wire logic                    por_rst,
  input  wire logic                    src_power_on,
  input  wire logic                    src_low_voltage,
  input  wire logic                    src_pin,
  input  wire logic                    src_watchdog,
  input  wire logic                    src_osc_fail,
  input  wire logic                    src_software,
  input  wire logic                    src_wakeup,
  input  wire logic                    serial_cs_n,
  input  wire logic                    serial_prog_enable,
  input  wire logic                    low_power_boot_option,
  input  wire logic                    debugger_active,
  input  wire logic                    rtc_wake_req,
  input  wire logic                    mode_wr,
  input  wire rsw_pkg::rsw_mode_t      mode_wdata,
  input  wire logic [N_GATES-1:0]      gate_wdata,
  input  wire logic                    gate_wr,
  input  wire logic                    in_stop,
  input  wire logic                    in_reduced_stop,
  input  wire logic                    mod_tick,
  output rsw_pkg::rsw_cause_t          reset_cause_status,
  output rsw_pkg::rsw_mode_t           mode_status,
  output rsw_pkg::rsw_exit_t           exit_status,
  output rsw_pkg::rsw_boot_t           boot_mode,
  output logic                         ram_valid,
  output logic                         regfile_valid,
  output logic                         debug_clk_en,
  output logic                         debug_enabled,
  output logic                         wake_out,
  output logic                         keep_retained_units,
  output logic [N_GATES-1:0]           module_clk_en
);
  import rsw_pkg::*;

  // ----------------------------------------------------------------
  // synchronised pins
  // ----------------------------------------------------------------
  localparam int unsigned NS = 12;
  logic [NS-1:0] pin_raw;
  logic [NS-1:0] pin_s;

  assign pin_raw = {src_power_on, src_low_voltage, src_pin, src_watchdog, src_osc_fail,
                    src_software, src_wakeup, serial_cs_n, serial_prog_enable,
                    low_power_boot_option, debugger_active, rtc_wake_req};

  // pin flops stay unreset: power-on reset must still see chip-select and option pins
  rsw_sync #(.W(NS)) u_sync (
    .clk  (clk),
    .rst  (1'b0),
    .din  (pin_raw),
    .dout (pin_s)
  );

  rsw_cause_t src_now;
  wire        cs_n_s       = pin_s[4];
  wire        sp_en_s      = pin_s[3];
  wire        lp_boot_s    = pin_s[2];
  wire        dbg_s        = pin_s[1];
  wire        rtc_wake_s   = pin_s[0];
  assign src_now = rsw_cause_t'(pin_s[NS-1:5]);

  // ----------------------------------------------------------------
  // reset cause capture
  // ----------------------------------------------------------------
  // causes accumulate while the warm reset is held (power-on reset holds the power-flag seed), and the set is replaced at release,
  // so software only ever sees the latest reset's sources.
  rsw_cause_t cause_acc_reg;
  rsw_cause_t cause_acc_next;
  logic       rst_d_reg;
  logic       in_reset;
  logic       release_evt;

  assign in_reset       = rst | por_rst;
  assign release_evt    = rst_d_reg & ~in_reset;
  assign cause_acc_next = in_reset ? rsw_cause_t'(cause_acc_reg | src_now)
                                   : rsw_cause_t'('0);

  // power-on seeds both power flags, so they survive sources that drop early
  always_ff @(posedge clk)
  begin
    rst_d_reg <= in_reset;
    if (por_rst)
      cause_acc_reg <= '{power_on: 1'b1, low_voltage: 1'b1, default: 1'b0};
    else
      cause_acc_reg <= cause_acc_next;
  end

  always_ff @(posedge clk)
  begin
    if (por_rst)
      reset_cause_status <= '{power_on: 1'b1, low_voltage: 1'b1, default: 1'b0};
    else if (release_evt)
      reset_cause_status <= cause_acc_reg | src_now;
  end

  wire power_flags = reset_cause_status.power_on & reset_cause_status.low_voltage;

  // ----------------------------------------------------------------
  // mode-controller registers, cleared only by power-on reset
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (por_rst)
      mode_status <= '{PROT_RST, CTRL_RST, STOPC_RST, DEPTH_0};
    else if (mode_wr & ~rst)
      mode_status <= mode_wdata;
  end

  // ----------------------------------------------------------------
  // exit identification and retention
  // ----------------------------------------------------------------
  logic [STOP_MODE_SELECT_W-1:0] stop_mode_select;
  logic [DEPTH_W-1:0] depth;
  logic               woke;
  logic               deep;
  rsw_exit_t          exit_next;

  assign stop_mode_select = mode_status.mode_control_reg[STOP_MODE_SELECT_W-1:0];
  assign depth = mode_status.retention_level_reg;
  assign woke  = reset_cause_status.wakeup;
  assign deep  = woke & (stop_mode_select == STOP_MODE_SELECT_DEEP);
  assign exit_next.leak_exit  = woke & (stop_mode_select == STOP_MODE_SELECT_LEAK);
  assign exit_next.deep0_exit = deep & (depth == DEPTH_0);
  assign exit_next.deep1_exit = deep & (depth == DEPTH_1);
  assign exit_next.deep2_exit = deep & (depth == DEPTH_2);
  assign exit_next.deep3_exit = deep & (depth == DEPTH_3);

  wire ram_kept = ~power_flags & (~deep | (depth >= DEPTH_2));
  wire rf_kept  = ~power_flags;

  always_ff @(posedge clk)
  begin
    if (por_rst)
    begin
      exit_status   <= '0;
      ram_valid     <= 1'b0;
      regfile_valid <= 1'b0;
    end
    else
    begin
      exit_status   <= exit_next;
      ram_valid     <= ram_kept;
      regfile_valid <= rf_kept;
    end
  end

  // ----------------------------------------------------------------
  // boot selection, latched at each reset release
  // ----------------------------------------------------------------
  rsw_boot_t boot_next;
  wire       power_cause = src_now.power_on | src_now.low_voltage |
                           cause_acc_reg.power_on | cause_acc_reg.low_voltage;

  assign boot_next = (power_cause & ~cs_n_s & sp_en_s) ? BOOT_SERIAL_PROG
                   : (lp_boot_s ? BOOT_NORMAL : BOOT_LOW_POWER);

  always_ff @(posedge clk)
  begin
    if (por_rst)
      boot_mode <= BOOT_NORMAL;
    else if (release_evt)
      boot_mode <= boot_next;
  end

  // ----------------------------------------------------------------
  // debug enable and debug clock keep-alive
  // ----------------------------------------------------------------
  // any wakeup recovery (leak stop or any deep level) drops debug so current readings match mission mode.
  logic dbg_reg;

  always_ff @(posedge clk)
  begin
    if (por_rst)
      dbg_reg <= 1'b0;
    else if (release_evt)
      dbg_reg <= dbg_s & ~(src_now.wakeup | cause_acc_reg.wakeup) ? 1'b1 :
                 ((src_now.wakeup | cause_acc_reg.wakeup) ? 1'b0 : dbg_reg);
  end

  always_ff @(posedge clk)
  begin
    if (rst | por_rst)
    begin
      debug_enabled <= 1'b0;
      debug_clk_en  <= 1'b0;
    end
    else
    begin
      debug_enabled <= dbg_reg;
      debug_clk_en  <= ~(in_stop | in_reduced_stop) | dbg_reg;
    end
  end

  // ----------------------------------------------------------------
  // clock gates, real-time wake, retained-unit hold
  // ----------------------------------------------------------------
  logic [N_GATES-1:0] gate_reg;

  always_ff @(posedge clk)
  begin
    if (rst | por_rst)
      gate_reg <= GATE_RST;
    else if (gate_wr)
      gate_reg <= gate_wdata;
  end

  rsw_gate #(.N(N_GATES)) u_gate (
    .clk     (clk),
    .rst     (rst | por_rst),
    .gate    (gate_reg),
    .en_tick (mod_tick),
    .mod_en  (module_clk_en)
  );

  always_ff @(posedge clk)
  begin
    if (por_rst)
    begin
      wake_out            <= 1'b0;
      keep_retained_units <= 1'b0;
    end
    else
    begin
      wake_out            <= rtc_wake_s;
      keep_retained_units <= rst & ~por_rst & (src_now.wakeup | cause_acc_reg.wakeup);
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_por_flags_set: assert property (@(posedge clk) $fell(por_rst) |->
    reset_cause_status.power_on && reset_cause_status.low_voltage)
    else $error("power flags not set after power-on");

  a_mode_kept_warm: assert property (@(posedge clk) disable iff (por_rst)
    (rst && !mode_wr) |=> $stable(mode_status))
    else $error("mode registers changed by warm reset");

  a_leak_exit_id: assert property (@(posedge clk) disable iff (por_rst)
    (woke && stop_mode_select == STOP_MODE_SELECT_LEAK) |=> exit_status.leak_exit)
    else $error("leak stop exit not flagged");

  a_deep_level_id: assert property (@(posedge clk) disable iff (por_rst)
    (deep && depth == DEPTH_2) |=> exit_status.deep2_exit && !exit_status.deep1_exit)
    else $error("deep level exit wrong");

  a_ram_lost_shallow: assert property (@(posedge clk) disable iff (por_rst)
    (deep && depth < DEPTH_2) |=> !ram_valid)
    else $error("ram claimed valid after deep level 0 or 1");

  a_regfile_kept: assert property (@(posedge clk) disable iff (por_rst)
    (!power_flags) |=> regfile_valid)
    else $error("register file lost");

  a_serial_boot_gate: assert property (@(posedge clk) disable iff (por_rst)
    (release_evt && !sp_en_s) |=> boot_mode != BOOT_SERIAL_PROG)
    else $error("serial boot despite disable");

  a_lp_boot_sel: assert property (@(posedge clk) disable iff (por_rst)
    (release_evt && !power_cause && !lp_boot_s) |=> boot_mode == BOOT_LOW_POWER)
    else $error("low power boot not chosen");

  a_dbg_clk_stop: assert property (@(posedge clk) disable iff (por_rst || rst)
    (dbg_reg && in_stop) |=> debug_clk_en)
    else $error("debug clock stopped while debugger active");

  a_gate_stops: assert property (@(posedge clk) disable iff (por_rst || rst)
    (!gate_reg[0]) |=> !module_clk_en[0])
    else $error("gated module still clocked");

endmodule : rsw_top

// file: design/rsw_pkg.sv
// rsw_pkg: shared constants and carriers for the reset-cause and wakeup status block.
// assumes one 100 MHz clock domain and a synchronous active-high reset.
package rsw_pkg;

  // ----------------------------------------------------------------
  // widths and encodings
  // ----------------------------------------------------------------
  localparam int unsigned STOP_MODE_SELECT_W   = 3;
  localparam int unsigned DEPTH_W   = 3;
  localparam int unsigned NUM_GATES = 8;

  localparam logic [STOP_MODE_SELECT_W-1:0] STOP_MODE_SELECT_NORMAL = 3'h0;
  localparam logic [STOP_MODE_SELECT_W-1:0] STOP_MODE_SELECT_LEAK   = 3'h3;
  localparam logic [STOP_MODE_SELECT_W-1:0] STOP_MODE_SELECT_DEEP   = 3'h4;

  localparam logic [DEPTH_W-1:0] DEPTH_0 = 3'h0;
  localparam logic [DEPTH_W-1:0] DEPTH_1 = 3'h1;
  localparam logic [DEPTH_W-1:0] DEPTH_2 = 3'h2;
  localparam logic [DEPTH_W-1:0] DEPTH_3 = 3'h3;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0]           PROT_RST  = 8'h00;
  localparam logic [7:0]           CTRL_RST  = 8'h00;
  localparam logic [7:0]           STOPC_RST = 8'h00;
  localparam logic [NUM_GATES-1:0] GATE_RST  = 8'h00;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic power_on;
    logic low_voltage;
    logic pin;
    logic watchdog;
    logic osc_fail;
    logic software;
    logic wakeup;
  } rsw_cause_t;

  typedef struct packed {
    logic [7:0]         mode_protection_reg;
    logic [7:0]         mode_control_reg;
    logic [7:0]         stop_control_reg;
    logic [DEPTH_W-1:0] retention_level_reg;
  } rsw_mode_t;

  typedef struct packed {
    logic leak_exit;
    logic deep0_exit;
    logic deep1_exit;
    logic deep2_exit;
    logic deep3_exit;
  } rsw_exit_t;

  typedef enum logic [1:0] {
    BOOT_NORMAL,
    BOOT_LOW_POWER,
    BOOT_SERIAL_PROG
  } rsw_boot_t;

endpackage : rsw_pkg

// file: design/rsw_sync.sv
// rsw_sync: two-flop synchroniser for a bundle of asynchronous levels.
// assumes the inputs come from pins or other clock domains.
module rsw_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  logic [W-1:0] meta_reg;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      meta_reg <= '0;
      dout     <= '0;
    end
    else
    begin
      meta_reg <= din;
      dout     <= meta_reg;
    end
  end
endmodule : rsw_sync

// file: design/rsw_gate.sv
// rsw_gate: per-module clock enable gating, one enable per peripheral.
// assumes en_tick is a one-cycle pulse of the slower module rate.
module rsw_gate #(
  parameter int unsigned N = 8
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [N-1:0] gate,
  input  wire logic         en_tick,
  output logic      [N-1:0] mod_en
);
  // ----------------------------------------------------------------
  // one gated enable per module
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < N; g++)
    begin : g_gate
      always_ff @(posedge clk)
      begin
        if (rst)
          mod_en[g] <= 1'b0;
        else
          mod_en[g] <= en_tick & gate[g];
      end
    end
  endgenerate
endmodule : rsw_gate

// file: tb/rsw_src_model.sv
// rsw_src_model: reset sources and wakeup unit seen from the block.
// assumes the bench fires it while a reset is held.
module rsw_src_model
  import rsw_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       fire,
  input  wire logic [6:0] cause,
  input  wire logic [2:0] len,
  output rsw_pkg::rsw_cause_t src
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0]  cnt_reg;
  rsw_cause_t  src_reg;
  initial
  begin
    cnt_reg = 3'h0;
    src_reg = '0;
  end
  // sources pulse for len cycles, then drop to their idle low level
  always @(posedge clk)
  begin
    if (fire)
    begin
      cnt_reg <= len;
      src_reg <= cause;
    end
    else if (cnt_reg > 3'h1)
      cnt_reg <= cnt_reg - 3'h1;
    else
    begin
      cnt_reg <= 3'h0;
      src_reg <= '0;
    end
  end
  assign src = src_reg;
endmodule : rsw_src_model

// file: tb/rsw_top_tb_top.sv
// rsw_top_tb_top: self-checking bench for rsw_top.
// assumes the design holds its own assertions; 100 MHz clock.
module rsw_top_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import rsw_pkg::*;
  logic clk, rst, por_rst, fire, cs_n, sp_en, lpb, dbg, rtc, mode_wr, gate_wr;
  logic in_stop, in_rstop, mod_tick;
  logic [6:0] cause;
  logic [2:0] len;
  logic [7:0] gate_wdata, g, seen;
  rsw_mode_t  mode_wdata, m;
  rsw_cause_t src, rcs;
  rsw_mode_t  mst;
  rsw_exit_t  est, e;
  rsw_boot_t  boot;
  logic ram_v, rf_v, dclk, den, wake, keep, keep_rst;
  logic [7:0] mclk;
  integer seed = 32'h698b;
  int failures = 0;
  int total_checks = 0;

  // ----------------------------------------------------------------
  // clock, partner and design
  // ----------------------------------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  rsw_src_model i_rsw_src_model (.clk(clk), .fire(fire), .cause(cause), .len(len), .src(src));
  rsw_top #(.N_GATES(8)) i_rsw_top (
    .clk(clk), .rst(rst), .por_rst(por_rst),
    .src_power_on(src.power_on), .src_low_voltage(src.low_voltage), .src_pin(src.pin),
    .src_watchdog(src.watchdog), .src_osc_fail(src.osc_fail),
    .src_software(src.software), .src_wakeup(src.wakeup),
    .serial_cs_n(cs_n), .serial_prog_enable(sp_en), .low_power_boot_option(lpb),
    .debugger_active(dbg), .rtc_wake_req(rtc), .mode_wr(mode_wr),
    .mode_wdata(mode_wdata), .gate_wdata(gate_wdata), .gate_wr(gate_wr),
    .in_stop(in_stop), .in_reduced_stop(in_rstop), .mod_tick(mod_tick),
    .reset_cause_status(rcs), .mode_status(mst), .exit_status(est), .boot_mode(boot),
    .ram_valid(ram_v), .regfile_valid(rf_v), .debug_clk_en(dclk), .debug_enabled(den),
    .wake_out(wake), .keep_retained_units(keep), .module_clk_en(mclk));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("[FAIL] t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask : chk

  task automatic close_out();
    $display("checks=%0d mismatches=%0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : close_out

  // sources are fired inside the reset so the cause accumulator sees them
  task automatic do_reset(input logic por, input logic [6:0] c);
    @(posedge clk);
    rst <= 1'b1;
    por_rst <= por;
    cause <= c;
    fire <= 1'b1;
    len <= 3'h3 + 3'($random(seed) & 3);
    @(posedge clk);
    fire <= 1'b0;
    repeat (6) @(posedge clk);
    keep_rst = keep;
    rst <= 1'b0;
    por_rst <= 1'b0;
    repeat (3) @(posedge clk);
  endtask : do_reset

  task automatic wr_mode(input rsw_mode_t v);
    @(posedge clk);
    mode_wr <= 1'b1;
    mode_wdata <= v;
    @(posedge clk);
    mode_wr <= 1'b0;
    repeat (2) @(posedge clk);
    chk(mst, v);
  endtask : wr_mode

  function automatic rsw_exit_t exp_exit(input rsw_mode_t v);
    rsw_exit_t r;
    r = '0;
    r.leak_exit = (v.mode_control_reg[2:0] == STOP_MODE_SELECT_LEAK);
    if (v.mode_control_reg[2:0] == STOP_MODE_SELECT_DEEP)
    begin
      r.deep0_exit = (v.retention_level_reg == DEPTH_0);
      r.deep1_exit = (v.retention_level_reg == DEPTH_1);
      r.deep2_exit = (v.retention_level_reg == DEPTH_2);
      r.deep3_exit = (v.retention_level_reg == DEPTH_3);
    end
    return r;
  endfunction : exp_exit

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial
  begin
    {rst, por_rst, fire, cs_n, sp_en, lpb} = 6'h3B;
    {dbg, rtc, mode_wr, gate_wr, in_stop, in_rstop, mod_tick} = 7'h00;
    cause = 7'h60;
    len = 3'h7;
    gate_wdata = 8'h00;
    mode_wdata = '0;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    por_rst <= 1'b0;
    fire <= 1'b0;
    repeat (3) @(posedge clk);
    chk(rcs, 7'h60);
    chk(mst, '0);
    chk(ram_v, 1'b0);
    chk(rf_v, 1'b0);
    chk(boot, BOOT_SERIAL_PROG);
    chk(mclk, 8'h00);
    sp_en <= 1'b0;
    lpb <= 1'b0;
    do_reset(1'b1, 7'h60);
    chk(boot, BOOT_LOW_POWER);
    lpb <= 1'b1;
    dbg <= 1'b1;
    do_reset(1'b0, 7'h20);
    chk(boot, BOOT_NORMAL);
    chk(den, 1'b1);
    in_stop <= 1'b1;
    in_rstop <= 1'b1;
    repeat (3) @(posedge clk);
    chk(dclk, 1'b1);
    in_stop <= 1'b0;
    in_rstop <= 1'b0;
    m = rsw_mode_t'($random(seed));
    wr_mode(m);
    for (int i = 0; i < 12; i++)
    begin
      cause = 7'($random(seed)) & 7'h1E;
      if (cause == 7'h00)
        cause = 7'h04;
      lpb <= 1'($random(seed));
      cs_n <= 1'($random(seed));
      sp_en <= 1'b1;
      do_reset(1'b0, cause);
      chk(rcs, cause);
      chk(boot, lpb ? BOOT_NORMAL : BOOT_LOW_POWER);
      chk(mst, m);
      chk(keep_rst, 1'b0);
    end
    lpb <= 1'b1;
    // wake-through-reset from the leak-limited stop and every deep level
    for (int d = -1; d < 4; d++)
    begin
      m = rsw_mode_t'($random(seed));
      m.mode_control_reg[2:0] = (d < 0) ? STOP_MODE_SELECT_LEAK : STOP_MODE_SELECT_DEEP;
      m.retention_level_reg = (d < 0) ? DEPTH_1 : 3'(d);
      wr_mode(m);
      do_reset(1'b0, 7'h01);
      e = exp_exit(m);
      chk(rcs, 7'h01);
      chk(mst, m);
      chk(est, e);
      chk(ram_v, (d < 0) || (d >= 2));
      chk(rf_v, 1'b1);
      chk(den, 1'b0);
      chk(dclk, 1'b1);
      chk(keep_rst, 1'b1);
      chk(keep, 1'b0);
    end
    in_stop <= 1'b1;
    repeat (3) @(posedge clk);
    chk(dclk, 1'b0);
    in_stop <= 1'b0;
    for (int i = 0; i < 4; i++)
    begin
      g = 8'($random(seed));
      @(posedge clk);
      gate_wr <= 1'b1;
      gate_wdata <= g;
      @(posedge clk);
      gate_wr <= 1'b0;
      repeat (3) @(posedge clk);
      chk(mclk, 8'h00);
      mod_tick <= 1'b1;
      @(posedge clk);
      mod_tick <= 1'b0;
      seen = 8'h00;
      repeat (3)
      begin
        @(posedge clk);
        seen = seen | mclk;
      end
      chk(seen, g);
    end
    chk(wake, 1'b0);
    rtc <= 1'b1;
    for (int k = 0; k < 8 && wake !== 1'b1; k++)
      @(posedge clk);
    chk(wake, 1'b1);
    rtc <= 1'b0;
    repeat (4) @(posedge clk);
    close_out();
  end

  // hang guard: the sequence needs well under 2000 cycles
  initial
  begin
    #200us;
    failures++;
    close_out();
  end
endmodule : rsw_top_tb_top
